//--- timer_module.sv
// Timer module with clock selection and AXI4-Lite register file
`timescale 1ns/1ps
module timer_module
  import timer_pkg::*;
#(
  parameter int unsigned PRESCALE   = PRESCALE_N,
  parameter int unsigned SYS_TM_DIV = SYS_TM_DIV_N,
  parameter int unsigned EXT_TM_DIV = EXT_TM_DIV_N
)
(
  // Clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  // Oscillator ticks, one cycle per oscillator period
  input  wire logic               internal_osc_tick_i,
  input  wire logic               external_osc_tick_i,
  // Neighbouring blocks
  input  wire logic [15:0]        prog_counter_a_i,
  input  wire logic               watchdog_timeout_flag_i,
  output logic      [15:0]        prog_counter_b_o,
  output logic      [7:0]         prog_counter_control_o,
  output logic      [7:0]         watchdog_control_o,
  output logic                    timer_clock_tick_o,
  // CPU interrupt
  output logic                    cpu_irq_o,
  output logic      [7:0]         irq_vector_o,
  output logic                    irq_o,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic      [1:0]         s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic      [31:0]        s_axi_rdata,
  output logic      [1:0]         s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);
  localparam int unsigned PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
  localparam int unsigned SW = $clog2(SYS_TM_DIV);
  localparam int unsigned EW = (EXT_TM_DIV > 1) ? $clog2(EXT_TM_DIV) : 1;
  localparam logic [ADDR_W-1:0] A_STATUS = ADDR_W'(IDX_STATUS * 4);
  localparam logic [ADDR_W-1:0] A_IRQF   = ADDR_W'(IDX_IRQF * 4);
  localparam logic [ADDR_W-1:0] A_IRQE   = ADDR_W'(IDX_IRQE * 4);
  localparam logic [ADDR_W-1:0] A_PCA_HI = ADDR_W'(IDX_PCA_HI * 4);
  localparam logic [ADDR_W-1:0] A_PCA_LO = ADDR_W'(IDX_PCA_LO * 4);
  localparam logic [ADDR_W-1:0] A_PCB_HI = ADDR_W'(IDX_PCB_HI * 4);
  localparam logic [ADDR_W-1:0] A_PCB_LO = ADDR_W'(IDX_PCB_LO * 4);
  localparam logic [ADDR_W-1:0] A_PCCTL  = ADDR_W'(IDX_PCCTL * 4);
  localparam logic [ADDR_W-1:0] A_WDT    = ADDR_W'(IDX_WDT * 4);
  localparam logic [ADDR_W-1:0] A_COUNT  = ADDR_W'(IDX_COUNT * 4);
  localparam logic [ADDR_W-1:0] A_TMCTL  = ADDR_W'(IDX_TMCTL * 4);
  localparam logic [ADDR_W-1:0] A_MCKSEL = ADDR_W'(IDX_MCKSEL * 4);
  localparam logic [ADDR_W-1:0] A_EVSTAT = ADDR_W'(IDX_EVSTAT * 4);
  localparam logic [ADDR_W-1:0] A_EVMASK = ADDR_W'(IDX_EVMASK * 4);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (PRESCALE < 2 || SYS_TM_DIV < 2 || EXT_TM_DIV < 2)
  begin : g_bad_div
    $error("timer_module: dividers must be at least 2");
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]         irqf_reg, irqe_reg, pcctl_reg, wdt_reg, cksel_reg;
  logic [7:0]         tmctl_reg, evstat_reg, evmask_reg;
  logic [15:0]        pcb_reg;
  logic               trst_reg;
  logic [COUNT_W-1:0] count_reg;
  logic               ext_half_reg;
  logic [1:0]         sdiv_reg;
  logic [SW-1:0]      sys_div_reg;
  logic [EW-1:0]      ext_div_reg;
  logic [PW-1:0]      presc_reg;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic              aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0]        w_data_reg;
  logic              w_lane_reg;
  logic [1:0]        bresp_reg, rresp_reg;
  logic [7:0]        rdata_reg;
  logic [7:0]        rd_mux;
  logic              rd_hit;

  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire  = s_axi_wvalid && s_axi_wready;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire wr_do   = aw_held_reg && w_held_reg;
  wire [ADDR_W-1:0] wa = {aw_addr_reg[ADDR_W-1:2], 2'b00};
  wire [ADDR_W-1:0] ra = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  wire wr_hit = (wa == A_STATUS) || (wa == A_IRQF) || (wa == A_IRQE) ||
                (wa == A_PCA_HI) || (wa == A_PCA_LO) || (wa == A_PCB_HI) ||
                (wa == A_PCB_LO) || (wa == A_PCCTL) || (wa == A_WDT) ||
                (wa == A_COUNT) || (wa == A_TMCTL) || (wa == A_MCKSEL) ||
                (wa == A_EVSTAT) || (wa == A_EVMASK);
  wire wr_en    = wr_do && w_lane_reg;
  wire wr_irqf  = wr_en && (wa == A_IRQF);
  wire wr_irqe  = wr_en && (wa == A_IRQE);
  wire wr_pcbh  = wr_en && (wa == A_PCB_HI);
  wire wr_pcbl  = wr_en && (wa == A_PCB_LO);
  wire wr_pcctl = wr_en && (wa == A_PCCTL);
  wire wr_wdt   = wr_en && (wa == A_WDT);
  wire wr_tmctl = wr_en && (wa == A_TMCTL);
  wire wr_cksel = wr_en && (wa == A_MCKSEL);
  wire wr_mask  = wr_en && (wa == A_EVMASK);
  wire rd_evst  = ar_fire && (ra == A_EVSTAT);

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = {24'h00_0000, rdata_reg};

  always_comb
  begin
    rd_hit = 1'b1;
    case (ra)
      A_STATUS: rd_mux = 8'(watchdog_timeout_flag_i) << WDT_TO_BIT;
      A_IRQF:   rd_mux = irqf_reg;
      A_IRQE:   rd_mux = irqe_reg;
      A_PCA_HI: rd_mux = prog_counter_a_i[15:8];
      A_PCA_LO: rd_mux = prog_counter_a_i[7:0];
      A_PCB_HI: rd_mux = pcb_reg[15:8];
      A_PCB_LO: rd_mux = pcb_reg[7:0];
      A_PCCTL:  rd_mux = pcctl_reg;
      A_WDT:    rd_mux = wdt_reg;
      A_COUNT:  rd_mux = count_reg;
      A_TMCTL:  rd_mux = {trst_reg, tmctl_reg[6:0]};
      A_MCKSEL: rd_mux = cksel_reg;
      A_EVSTAT: rd_mux = evstat_reg;
      A_EVMASK: rd_mux = evmask_reg;
      default:
      begin
        rd_mux = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Address and data are parked separately, so either may come first
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= 8'h00;
      w_lane_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_fire)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      if (wr_do)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 8'h00;
      rresp_reg  <= RESP_OKAY;
    end
    else if (ar_fire)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Clock selection chain, built as enable ticks on the core clock
  // ----------------------------------------------------------------
  wire main_src  = cksel_reg[SRC_BIT];
  wire ext_half  = cksel_reg[HALF_BIT];
  wire sdiv_sel  = cksel_reg[SDIV_BIT];
  wire tsel      = cksel_reg[TSEL_BIT];
  wire ext_tick  = external_osc_tick_i;
  wire half_tick = ext_tick && ext_half_reg;
  wire main_tick = !main_src ? internal_osc_tick_i :
                   (ext_half ? half_tick : ext_tick);
  wire sys_tick  = sdiv_sel ? (main_tick && (sdiv_reg == 2'(SYS_SLOW_N - 1)))
                            : main_tick;
  wire sys_wrap  = sys_div_reg == SW'(SYS_TM_DIV - 1);
  wire ext_wrap  = ext_div_reg == EW'(EXT_TM_DIV - 1);
  // External path is independent of main/system settings
  wire tm_tick   = tsel ? (ext_tick && ext_wrap)
                        : (sys_tick && sys_wrap);
  wire cnt_tick  = tm_tick && (presc_reg == PW'(PRESCALE - 1));

  assign timer_clock_tick_o = tm_tick;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ext_half_reg <= 1'b0;
      sdiv_reg     <= 2'h0;
      sys_div_reg  <= '0;
      ext_div_reg  <= '0;
    end
    else
    begin
      if (ext_tick)
        ext_half_reg <= !ext_half_reg;
      if (main_tick)
        sdiv_reg <= 2'(sdiv_reg + 2'h1);
      if (sys_tick)
        sys_div_reg <= sys_wrap ? '0 : SW'(sys_div_reg + 1'b1);
      if (ext_tick)
        ext_div_reg <= ext_wrap ? '0 : EW'(ext_div_reg + 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // Eight-bit counter and timeout detection
  // ----------------------------------------------------------------
  wire               run      = tmctl_reg[RUN_BIT];
  wire [2:0]         bit_sel  = tmctl_reg[2:0];
  wire               cnt_clr  = wr_tmctl && !w_data_reg[TRST_BIT];
  wire               cnt_step = cnt_tick && run && !cnt_clr;
  wire [COUNT_W-1:0] cnt_plus = COUNT_W'(count_reg + 1'b1);
  wire [COUNT_W-1:0] fall_vec;
  genvar gi;
  for (gi = 0; gi < COUNT_W; gi++)
  begin : g_fall
    assign fall_vec[gi] = count_reg[gi] && !cnt_plus[gi];
  end
  wire timeout_evt = cnt_step && fall_vec[bit_sel];
  wire wrap_evt    = cnt_step && (count_reg == {COUNT_W{1'b1}});

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      count_reg <= '0;
      presc_reg <= '0;
      trst_reg  <= 1'b1;
    end
    else
    begin
      trst_reg <= !cnt_clr;
      if (cnt_clr)
      begin
        count_reg <= '0;
        presc_reg <= '0;
      end
      else
      begin
        if (tm_tick)
          presc_reg <= (presc_reg == PW'(PRESCALE - 1)) ? '0
                       : PW'(presc_reg + 1'b1);
        if (cnt_step)
          count_reg <= cnt_plus;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers and interrupt flags
  // ----------------------------------------------------------------
  // A timeout in the clearing cycle keeps the flag set
  wire [7:0] irqf_next = (wr_irqf ? (w_data_reg & IRQF_MASK) : irqf_reg) |
                         (8'(timeout_evt) << TFLAG_BIT);
  wire [7:0] ev_in     = (8'(timeout_evt) << EV_TIMEOUT) |
                         (8'(wrap_evt) << EV_WRAP);
  wire [7:0] evstat_next = (rd_evst ? 8'h00 : evstat_reg) | ev_in;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      irqf_reg   <= REG_RST;
      irqe_reg   <= REG_RST;
      pcctl_reg  <= REG_RST;
      wdt_reg    <= REG_RST;
      cksel_reg  <= REG_RST;
      tmctl_reg  <= TMCTL_RST & TMCTL_MASK;
      evstat_reg <= REG_RST;
      evmask_reg <= REG_RST;
      pcb_reg    <= 16'h0000;
    end
    else
    begin
      irqf_reg   <= irqf_next;
      evstat_reg <= evstat_next;
      if (wr_irqe)
        irqe_reg <= w_data_reg & IRQE_MASK;
      if (wr_pcctl)
        pcctl_reg <= w_data_reg;
      if (wr_wdt)
        wdt_reg <= w_data_reg & WDT_MASK;
      if (wr_cksel)
        cksel_reg <= w_data_reg & CKSEL_MASK;
      if (wr_tmctl)
        tmctl_reg <= w_data_reg & TMCTL_MASK;
      if (wr_mask)
        evmask_reg <= w_data_reg & EV_MASK;
      if (wr_pcbh)
        pcb_reg[15:8] <= w_data_reg;
      if (wr_pcbl)
        pcb_reg[7:0] <= w_data_reg;
    end
  end

  assign cpu_irq_o = irqf_reg[TFLAG_BIT] && irqe_reg[TIEN_BIT] &&
                     irqe_reg[GIEN_BIT];
  assign irq_vector_o           = TIMER_VECTOR;
  assign irq_o                  = |(evstat_reg & evmask_reg);
  assign prog_counter_b_o       = pcb_reg;
  assign prog_counter_control_o = pcctl_reg;
  assign watchdog_control_o     = wdt_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_clear_write;
    wr_tmctl && !w_data_reg[TRST_BIT];
  endsequence
  sequence s_cleared_restored;
    (count_reg == '0 && !trst_reg) ##1 trst_reg;
  endsequence

  a_prescale_four: assert property (cnt_tick |->
    tm_tick && presc_reg == PW'(PRESCALE - 1))
    else $error("count tick without full prescale");
  a_count_steps: assert property (cnt_step |=>
    count_reg == COUNT_W'($past(count_reg) + 1'b1))
    else $error("counter did not step");
  a_count_holds: assert property (!run && !cnt_clr |=>
    $stable(count_reg))
    else $error("counter moved while stopped");
  a_reset_bit: assert property (s_clear_write |=>
    s_cleared_restored)
    else $error("timer reset bit misbehaved");
  a_timeout_bit: assert property (timeout_evt |=>
    !count_reg[$past(bit_sel)] && $past(count_reg[bit_sel]))
    else $error("timeout not on selected bit fall");
  a_flag_sets: assert property (timeout_evt |=>
    irqf_reg[TFLAG_BIT])
    else $error("timeout did not set flag");
  a_flag_sticky: assert property (irqf_reg[TFLAG_BIT] && !wr_irqf |=>
    irqf_reg[TFLAG_BIT])
    else $error("flag dropped without a clear");
  a_irq_gate: assert property (cpu_irq_o |->
    irqe_reg[GIEN_BIT] && irqe_reg[TIEN_BIT] && irqf_reg[TFLAG_BIT])
    else $error("interrupt passed while disabled");
  a_sys_quarter: assert property (sdiv_sel && sys_tick |->
    main_tick && sdiv_reg == 2'(SYS_SLOW_N - 1))
    else $error("system clock not main/4");
  a_timer_input_clock_ext: assert property (tsel && tm_tick |->
    ext_tick && ext_div_reg == EW'(EXT_TM_DIV - 1))
    else $error("timer clock not external/32");
  a_half_main: assert property (main_src && ext_half && main_tick |->
    ext_tick && ext_half_reg)
    else $error("main clock not external/2");
endmodule

//--- timer_module_and_counter_regs_bench.sv
// Self-checking bench for the timer module and its register file
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); \
    end \
  end

module timer_module_and_counter_regs_bench
  import timer_pkg::*;
;
  // ----------------------------------------------------------------
  // Shortened dividers keep the run short
  // ----------------------------------------------------------------
  localparam int unsigned TB_PRE = 2;
  localparam int unsigned TB_SYS = 2;
  localparam int unsigned TB_EXT = 2;
  localparam int          INC_P  = TB_EXT * TB_PRE;
  // ----------------------------------------------------------------
  // Design connections
  // ----------------------------------------------------------------
  logic              core_clk_i;
  logic              rst_i;
  logic              int_tick;
  logic              ext_tick;
  logic [15:0]       cnt_a;
  logic              wdt_to;
  logic [15:0]       cnt_b;
  logic [7:0]        pc_ctl;
  logic [7:0]        wd_ctl;
  logic              tm_tick;
  logic              cpu_irq;
  logic [7:0]        irq_vec;
  logic              irq;
  logic [ADDR_W-1:0] s_axi_awaddr;
  logic              s_axi_awvalid;
  logic              s_axi_awready;
  logic [31:0]       s_axi_wdata;
  logic              s_axi_wvalid;
  logic              s_axi_wready;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_bvalid;
  logic              s_axi_bready;
  logic [ADDR_W-1:0] s_axi_araddr;
  logic              s_axi_arvalid;
  logic              s_axi_arready;
  logic [31:0]       s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic              s_axi_rvalid;
  logic              s_axi_rready;
  logic [1:0]        div3;
  logic [7:0]        d;
  logic [1:0]        r;
  int                cyc;
  int                tick_cnt;
  int                t0;
  int                error_cnt;
  int                n_compared;

  timer_module #(.PRESCALE(TB_PRE), .SYS_TM_DIV(TB_SYS), .EXT_TM_DIV(TB_EXT))
  timer_module_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i),
    .internal_osc_tick_i(int_tick), .external_osc_tick_i(ext_tick),
    .prog_counter_a_i(cnt_a), .watchdog_timeout_flag_i(wdt_to),
    .prog_counter_b_o(cnt_b), .prog_counter_control_o(pc_ctl),
    .watchdog_control_o(wd_ctl), .timer_clock_tick_o(tm_tick),
    .cpu_irq_o(cpu_irq), .irq_vector_o(irq_vec), .irq_o(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );

  // ----------------------------------------------------------------
  // Clock, internal oscillator at a third of the core rate, watchdog
  // ----------------------------------------------------------------
  initial core_clk_i = 1'b0;
  always #5 core_clk_i = ~core_clk_i;

  always @(posedge core_clk_i)
  begin
    cyc++;
    if (tm_tick === 1'b1)
      tick_cnt++;
    div3     <= (div3 == 2'd2) ? 2'd0 : div3 + 2'd1;
    int_tick <= (div3 == 2'd2);
    if (cyc == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks; each is entered right after a rising edge
  // ----------------------------------------------------------------
  task automatic wr(input int unsigned idx, input logic [7:0] v);
    s_axi_awaddr  <= ADDR_W'(idx * 4);
    s_axi_wdata   <= {24'h0000_00, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do
    begin
      @(posedge core_clk_i);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid === 1'b1 && s_axi_bready));
    `CHK(s_axi_bresp, RESP_OKAY)
  endtask

  task automatic rd(input int unsigned idx);
    s_axi_araddr  <= ADDR_W'(idx * 4);
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge core_clk_i);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid === 1'b1 && s_axi_rready));
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
  endtask

  function automatic logic near(input int a, input int b, input int t);
    return (a >= b - t) && (a <= b + t);
  endfunction

  // Timer clock ticks over 240 cycles; divider phase allows one off
  task automatic rate(input logic [7:0] m, input int e);
    wr(IDX_MCKSEL, m);
    repeat (24) @(posedge core_clk_i);
    t0 = tick_cnt;
    repeat (240) @(posedge core_clk_i);
    `CHK(near(tick_cnt - t0, e, 1), 1'b1)
  endtask

  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst_i, int_tick, ext_tick, wdt_to, div3} = {1'b1, 1'b0, 1'b1, 1'b0, 2'd0};
    // Response ready lines stay high, so back-to-back calls never
    // lower and raise them within one time step
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b001;
    {s_axi_arvalid, s_axi_rready} = 2'b01;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    cnt_a = 16'h1234;
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    rd(IDX_TMCTL); `CHK(d, 8'h80)
    rd(IDX_COUNT); `CHK(d, 8'h00)
    rd(IDX_IRQF); `CHK(d, 8'h00)
    rd(IDX_IRQE); `CHK(d, 8'h00)
    rd(IDX_MCKSEL); `CHK(d, 8'h00)
    wr(IDX_PCB_HI, 8'ha5);
    wr(IDX_PCB_LO, 8'h5a);
    rd(IDX_PCB_HI); `CHK(d, 8'ha5)
    rd(IDX_PCB_LO); `CHK(d, 8'h5a)
    `CHK(cnt_b, 16'ha55a)
    wr(IDX_PCA_HI, 8'hff);
    rd(IDX_PCA_HI); `CHK(d, 8'h12)
    rd(IDX_PCA_LO); `CHK(d, 8'h34)
    wr(IDX_PCCTL, 8'h5c); `CHK(pc_ctl, 8'h5c)
    wr(IDX_WDT, 8'hff); `CHK(wd_ctl, WDT_MASK)
    rd('h3f); `CHK(r, RESP_SLVERR)
    wdt_to <= 1'b1;
    rd(IDX_STATUS); `CHK(d[WDT_TO_BIT], 1'b1)
    // Internal oscillator ticks every third cycle, external tick every cycle
    rate(8'h00, 240 / (3 * TB_SYS));
    rate(8'h02, 240 / (12 * TB_SYS));
    rate(8'h01, 240 / TB_SYS);
    rate(8'h09, 240 / (2 * TB_SYS));
    rate(8'h0b, 240 / (8 * TB_SYS));
    rate(8'h2b, 240 / TB_EXT);
    rate(8'h20, 240 / TB_EXT);
    wr(IDX_TMCTL, 8'h08);
    repeat (400) @(posedge core_clk_i);
    rd(IDX_COUNT); `CHK(near(int'(d), 400 / INC_P, 4), 1'b1)
    wr(IDX_TMCTL, 8'h00);
    rd(IDX_TMCTL); `CHK(d, 8'h80)
    repeat (40) @(posedge core_clk_i);
    rd(IDX_COUNT); `CHK(d, 8'h00)
    // Each select code: first fall of bit k after 2^(k+1) steps
    wr(IDX_IRQE, 8'h90);
    for (int k = 0; k < 8; k++)
    begin
      wr(IDX_TMCTL, {5'h00, 3'(k)});
      wr(IDX_IRQF, 8'h00);
      `CHK(cpu_irq, 1'b0)
      wr(IDX_TMCTL, 8'h08 | {5'h00, 3'(k)});
      t0 = cyc;
      while (cpu_irq !== 1'b1)
        @(posedge core_clk_i);
      `CHK(near(cyc - t0, INC_P << (k + 1), 4), 1'b1)
      if (k == 3)
        `CHK(irq, 1'b0)
    end
    `CHK(irq_vec, TIMER_VECTOR)
    repeat (20) @(posedge core_clk_i);
    rd(IDX_IRQF); `CHK(d, 8'h10)
    wr(IDX_IRQE, 8'h10); `CHK(cpu_irq, 1'b0)
    wr(IDX_IRQE, 8'h80); `CHK(cpu_irq, 1'b0)
    wr(IDX_IRQE, 8'h90); `CHK(cpu_irq, 1'b1)
    wr(IDX_TMCTL, 8'h00);
    wr(IDX_EVMASK, 8'h03); `CHK(irq, 1'b1)
    rd(IDX_EVSTAT); `CHK(d, 8'h03)
    `CHK(irq, 1'b0)
    rd(IDX_EVSTAT); `CHK(d, 8'h00)
    wr(IDX_IRQF, 8'h00); `CHK(cpu_irq, 1'b0)
    report_and_stop();
  end
endmodule

//--- timer_pkg.sv
// Constants shared by the timer module and its register file
package timer_pkg;
  // ----------------------------------------------------------------
  // Clock rates and divider figures
  // ----------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ  = 100_000_000;
  localparam int unsigned INT_OSC_HZ   = 1_000_000;
  localparam int unsigned EXT_OSC_HZ   = 32768;
  localparam int unsigned PRESCALE_N   = 4;
  localparam int unsigned SYS_TM_DIV_N = 1000;
  localparam int unsigned EXT_TM_DIV_N = 32;
  localparam int unsigned SYS_SLOW_N   = 4;
  localparam int unsigned TIN_EXT_HZ   = EXT_OSC_HZ / EXT_TM_DIV_N;
  localparam int unsigned COUNT_W      = 8;
  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned IDX_STATUS  = 'h04;
  localparam int unsigned IDX_IRQF    = 'h06;
  localparam int unsigned IDX_IRQE    = 'h07;
  localparam int unsigned IDX_PCA_HI  = 'h08;
  localparam int unsigned IDX_PCA_LO  = 'h09;
  localparam int unsigned IDX_PCB_HI  = 'h0a;
  localparam int unsigned IDX_PCB_LO  = 'h0b;
  localparam int unsigned IDX_PCCTL   = 'h0c;
  localparam int unsigned IDX_WDT     = 'h0d;
  localparam int unsigned IDX_COUNT   = 'h0e;
  localparam int unsigned IDX_TMCTL   = 'h0f;
  localparam int unsigned IDX_MCKSEL  = 'h14;
  localparam int unsigned IDX_EVSTAT  = 'h20;
  localparam int unsigned IDX_EVMASK  = 'h21;
  // ----------------------------------------------------------------
  // Field positions, masks, reset values
  // ----------------------------------------------------------------
  localparam int unsigned WDT_TO_BIT  = 3;
  localparam int unsigned TFLAG_BIT   = 4;
  localparam int unsigned TIEN_BIT    = 4;
  localparam int unsigned GIEN_BIT    = 7;
  localparam int unsigned TRST_BIT    = 7;
  localparam int unsigned RUN_BIT     = 3;
  localparam int unsigned SRC_BIT     = 0;
  localparam int unsigned SDIV_BIT    = 1;
  localparam int unsigned HALF_BIT    = 3;
  localparam int unsigned TSEL_BIT    = 5;
  localparam int unsigned EV_TIMEOUT  = 0;
  localparam int unsigned EV_WRAP     = 1;
  localparam logic [7:0] TMCTL_RST    = 8'h80;
  localparam logic [7:0] TMCTL_MASK   = 8'h0f;
  localparam logic [7:0] WDT_MASK     = 8'h87;
  localparam logic [7:0] CKSEL_MASK   = 8'hef;
  localparam logic [7:0] IRQF_MASK    = 8'h10;
  localparam logic [7:0] IRQE_MASK    = 8'h90;
  localparam logic [7:0] EV_MASK      = 8'h03;
  localparam logic [7:0] REG_RST      = 8'h00;
  localparam logic [7:0] TIMER_VECTOR = 8'h04;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage
